//--- hdl/rpp_pkg.sv
// Package of constants and carrier types for the raster pixel pipeline
package rpp_pkg;

    // Pixel depth modes
    typedef enum logic [1:0] {
        RPP_BPP4  = 2'h0,
        RPP_BPP8  = 2'h1,
        RPP_BPP16 = 2'h3
    } rpp_depth_t;

    // Blink transforms
    typedef enum logic [2:0] {
        RPP_BLK_AND     = 3'h0,
        RPP_BLK_OR      = 3'h1,
        RPP_BLK_XOR     = 3'h2,
        RPP_BLK_BACK    = 3'h3,
        RPP_BLK_DIM     = 3'h4,
        RPP_BLK_BRIGHT  = 3'h5,
        RPP_BLK_REVERSE = 3'h6
    } rpp_blink_t;

    // Fetch state machine, Gray coded from IDLE through REQ and WAIT to DRAIN
    typedef enum logic [1:0] {
        RPP_ST_IDLE  = 2'h0,
        RPP_ST_REQ   = 2'h1,
        RPP_ST_WAIT  = 2'h3,
        RPP_ST_DRAIN = 2'h2
    } rpp_state_t;

    localparam int          RPP_ADDR_W     = 32;
    localparam int          RPP_WORD_BYTES = 4;
    localparam int          RPP_LUT_DEPTH  = 256;
    localparam int          RPP_COLOR_W    = 24;
    localparam logic [1:0]  RPP_WORD_ALIGN = 2'h0;
    localparam logic [7:0]  RPP_FRAME_RST  = 8'h00;
    localparam logic [3:0]  RPP_DIM_SHIFT  = 4'h1;
    localparam int          RPP_SHADE_BITS = 3;
    localparam int          RPP_SHADES     = 8;

    // Memory read request
    typedef struct packed {
        logic                  valid;
        logic [RPP_ADDR_W-1:0] addr;
        logic                  vram;
    } rpp_mreq_t;

    // LUT write port
    typedef struct packed {
        logic                   we;
        logic                   sel;
        logic [7:0]             idx;
        logic [RPP_COLOR_W-1:0] color;
    } rpp_lutw_t;

    // Output pixel
    typedef struct packed {
        logic                   valid;
        logic                   sof;
        logic                   eol;
        logic [RPP_COLOR_W-1:0] rgb;
    } rpp_pix_t;

endpackage : rpp_pkg

//--- hdl/rpp_pipeline.sv
// Raster pixel pipeline: fetch, unpack, LUT, blink and dither
//
// Contract
// - Blink cadence follows blink period rate field
// - 4/8 bpp blink flagged by masked match of index bit planes
// - 16 bpp blink is logic transform of pixel; code applies only background/dim/bright/reverse, to every pixel
// - AND/OR/XOR, background, dim, bright, reverse transforms
// - Two 256-entry tables of 24-bit colours
// - Mono dither: 8 shades from 3 bits
// - Colour dither: 512 colours, 3 bits each
// - Dither decision from frame, position, value
// - Line pitch may exceed visible line width
// - Line start on any word boundary
// - Top-left address from screen start input
// - Fetch ascending words, lines top to bottom
// - Frame buffer in system or video memory
// - First pixel out is pixel 0, word 0
// - 4 bpp: bytes ascending, upper nibble first
// - 8 bpp: byte 0 first through byte 3
// - 16 bpp: low halfword first, then high
module rpp_pipeline #(
    parameter int LINE_WORDS_W = 12, // Width of words-per-line counts
    parameter int LINES_W      = 11  // Width of line counts
) (
    input  wire logic                          clk,            // 125 MHz clock
    input  wire logic                          rst_b,          // Synchronous reset, low
    input  wire logic                          enable,         // Run frames
    input  wire rpp_pkg::rpp_depth_t           depth,          // Pixel depth mode
    input  wire logic [rpp_pkg::RPP_ADDR_W-1:0] screen_start,  // Top-left word address
    input  wire logic                          vram_sel,       // Read dedicated video memory
    input  wire logic [LINE_WORDS_W-1:0]       line_words,     // Visible words per line
    input  wire logic [LINE_WORDS_W-1:0]       line_pitch,     // Memory words per line
    input  wire logic [LINES_W-1:0]            frame_lines,    // Lines per frame
    input  wire logic [7:0]                    blink_period_register, // Blink rate field
    input  wire logic [7:0]                    blink_mask,     // Bit planes tested
    input  wire logic [7:0]                    blink_match,    // Value of blinking index
    input  wire logic [7:0]                    blink_operand,  // Operand for AND/OR/XOR
    input  wire rpp_pkg::rpp_blink_t           blink_mode,     // Blink transform
    input  wire logic [rpp_pkg::RPP_COLOR_W-1:0] background,   // Blink background colour
    input  wire logic                          lut_sel,        // LUT used for display
    input  wire logic                          dither_en,      // Enable dithering
    input  wire logic                          dither_mono,    // Grayscale dither
    input  wire rpp_pkg::rpp_lutw_t            lut_wr,         // LUT write port
    output rpp_pkg::rpp_mreq_t                 mem_req,        // Memory read request
    input  wire logic                          mem_ack,        // Request taken
    input  wire logic                          mem_rvalid,     // Read data valid
    input  wire logic [31:0]                   mem_rdata,      // Read data
    output rpp_pkg::rpp_pix_t                  pix_out,        // Pixel stream
    input  wire logic                          pix_ready,      // Display takes a pixel
    output logic                               blink_phase_q,  // High in blink off phase
    output logic [7:0]                         frame_cnt_q     // Frame counter
);

    initial begin
        if (LINE_WORDS_W < 1 || LINE_WORDS_W > 20 || LINES_W < 1 || LINES_W > 16)
            $error("rpp_pipeline: unsupported counter width");
    end

    rpp_pkg::rpp_state_t         state_q;
    logic [rpp_pkg::RPP_ADDR_W-1:0] line_addr_q;
    logic [rpp_pkg::RPP_ADDR_W-1:0] word_addr_q;
    logic [LINE_WORDS_W-1:0]     word_cnt_q;
    logic [LINES_W-1:0]          line_cnt_q;
    logic [31:0]                 word_q;
    logic [2:0]                  slot_q;
    logic                        first_q;
    logic                        last_word_q;
    logic [LINE_WORDS_W+2:0]     xpos_q;
    logic [rpp_pkg::RPP_COLOR_W-1:0] lut0 [rpp_pkg::RPP_LUT_DEPTH];
    logic [rpp_pkg::RPP_COLOR_W-1:0] lut1 [rpp_pkg::RPP_LUT_DEPTH];
    logic [7:0]                  blink_cnt_q;
    rpp_pkg::rpp_mreq_t          mem_req_q;
    rpp_pkg::rpp_pix_t           pix_q;

    logic [2:0]  slots_last;
    logic [15:0] raw_pix;
    logic        out_fire;
    logic        last_slot;
    logic        last_line;

    always_comb begin
        case (depth)
            rpp_pkg::RPP_BPP4:  slots_last = 3'h7;
            rpp_pkg::RPP_BPP8:  slots_last = 3'h3;
            default:            slots_last = 3'h1;
        endcase
    end

    // Unpack order
    always_comb begin
        raw_pix = 16'h0000;
        case (depth)
            rpp_pkg::RPP_BPP4:
                raw_pix = {12'h000, word_q[{slot_q[2:1], ~slot_q[0], 2'h0} +: 4]};
            rpp_pkg::RPP_BPP8:
                raw_pix = {8'h00, word_q[{slot_q[1:0], 3'h0} +: 8]};
            default:
                raw_pix = word_q[{slot_q[0], 4'h0} +: 16];
        endcase
    end

    assign last_slot = (slot_q == slots_last);
    assign last_line = (line_cnt_q == frame_lines - LINES_W'(1));
    assign out_fire  = (state_q == rpp_pkg::RPP_ST_DRAIN) && (!pix_q.valid || pix_ready);

    // Fetch sequencing
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_q     <= rpp_pkg::RPP_ST_IDLE;
            line_addr_q <= '0;
            word_addr_q <= '0;
            word_cnt_q  <= '0;
            line_cnt_q  <= '0;
            word_q      <= 32'h0000_0000;
            slot_q      <= 3'h0;
            first_q     <= 1'b0;
            last_word_q <= 1'b0;
            mem_req_q   <= '0;
        end else begin
            case (state_q)
                rpp_pkg::RPP_ST_IDLE: begin
                    if (enable) begin
                        line_addr_q <= {screen_start[rpp_pkg::RPP_ADDR_W-1:2],
                                        rpp_pkg::RPP_WORD_ALIGN};
                        word_addr_q <= {screen_start[rpp_pkg::RPP_ADDR_W-1:2],
                                        rpp_pkg::RPP_WORD_ALIGN};
                        word_cnt_q  <= '0;
                        line_cnt_q  <= '0;
                        first_q     <= 1'b1;
                        state_q     <= rpp_pkg::RPP_ST_REQ;
                    end
                end
                rpp_pkg::RPP_ST_REQ: begin
                    mem_req_q.valid <= 1'b1;
                    mem_req_q.addr  <= word_addr_q;
                    mem_req_q.vram  <= vram_sel;
                    if (mem_req_q.valid && mem_ack) begin
                        mem_req_q.valid <= 1'b0;
                        state_q         <= rpp_pkg::RPP_ST_WAIT;
                    end
                end
                rpp_pkg::RPP_ST_WAIT: begin
                    if (mem_rvalid) begin
                        word_q      <= mem_rdata;
                        slot_q      <= 3'h0;
                        last_word_q <= (word_cnt_q == line_words - LINE_WORDS_W'(1));
                        state_q     <= rpp_pkg::RPP_ST_DRAIN;
                    end
                end
                default: begin
                    if (out_fire) begin
                        first_q <= 1'b0;
                        slot_q  <= slot_q + 3'h1;
                        if (last_slot) begin
                            if (!last_word_q) begin
                                word_cnt_q  <= word_cnt_q + LINE_WORDS_W'(1);
                                word_addr_q <= word_addr_q + rpp_pkg::RPP_ADDR_W'(
                                               rpp_pkg::RPP_WORD_BYTES);
                                state_q     <= rpp_pkg::RPP_ST_REQ;
                            end else if (!last_line) begin
                                line_addr_q <= line_addr_q + rpp_pkg::RPP_ADDR_W'(
                                               {line_pitch, 2'h0});
                                word_addr_q <= line_addr_q + rpp_pkg::RPP_ADDR_W'(
                                               {line_pitch, 2'h0});
                                word_cnt_q  <= '0;
                                line_cnt_q  <= line_cnt_q + LINES_W'(1);
                                state_q     <= rpp_pkg::RPP_ST_REQ;
                            end else begin
                                state_q <= rpp_pkg::RPP_ST_IDLE;
                            end
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (lut_wr.we && !lut_wr.sel)
            lut0[lut_wr.idx] <= lut_wr.color;
        if (lut_wr.we && lut_wr.sel)
            lut1[lut_wr.idx] <= lut_wr.color;
    end

    // Frame count and blink cadence
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            frame_cnt_q   <= rpp_pkg::RPP_FRAME_RST;
            blink_cnt_q   <= 8'h00;
            blink_phase_q <= 1'b0;
        end else if (out_fire && last_slot && last_word_q && last_line) begin
            frame_cnt_q <= frame_cnt_q + 8'h01;
            if (blink_cnt_q >= blink_period_register) begin
                blink_cnt_q   <= 8'h00;
                blink_phase_q <= ~blink_phase_q;
            end else begin
                blink_cnt_q <= blink_cnt_q + 8'h01;
            end
        end
    end

    // Pixel position along the line
    always_ff @(posedge clk) begin
        if (!rst_b)
            xpos_q <= '0;
        else if (out_fire)
            xpos_q <= (last_slot && last_word_q) ? '0 : xpos_q + 1'b1;
    end

    logic [7:0]  idx;
    logic [7:0]  idx_bl;
    logic        flagged;
    logic [23:0] col;
    logic [23:0] col_bl;
    logic [23:0] col_dt;
    logic [2:0]  thr;

    always_comb begin
        idx    = raw_pix[7:0];
        idx_bl = idx;
        flagged = ((idx & blink_mask) == (blink_match & blink_mask));
        // 16 bpp marks every pixel for transform
        if (depth == rpp_pkg::RPP_BPP16)
            flagged = 1'b1;
        // only flagged pixels in off phase
        if (blink_phase_q && flagged && depth != rpp_pkg::RPP_BPP16) begin
            case (blink_mode)
                rpp_pkg::RPP_BLK_AND: idx_bl = idx & blink_operand;
                rpp_pkg::RPP_BLK_OR:  idx_bl = idx | blink_operand;
                rpp_pkg::RPP_BLK_XOR: idx_bl = idx ^ blink_operand;
                default:              idx_bl = idx;
            endcase
        end
        if (depth == rpp_pkg::RPP_BPP16)
            col = {raw_pix[15:11], 3'h0, raw_pix[10:5], 2'h0, raw_pix[4:0], 3'h0};
        else
            col = lut_sel ? lut1[idx_bl] : lut0[idx_bl];
        col_bl = col;
        if (blink_phase_q && flagged) begin
            case (blink_mode)
                rpp_pkg::RPP_BLK_BACK:    col_bl = background;
                rpp_pkg::RPP_BLK_DIM:     col_bl = (col >> rpp_pkg::RPP_DIM_SHIFT) & 24'h7F7F7F;
                rpp_pkg::RPP_BLK_BRIGHT:  col_bl = col | 24'h808080;
                rpp_pkg::RPP_BLK_REVERSE: col_bl = ~col;
                default:                  col_bl = col;
            endcase
        end
        thr = frame_cnt_q[2:0] + xpos_q[2:0] + {line_cnt_q[0], 2'h0}
              + {1'b0, line_cnt_q[1], 1'b0};
        col_dt = col_bl;
        if (dither_en) begin
            if (dither_mono) begin
                // eight shades from top 3 bits
                col_dt = (col_bl[23:21] > thr || col_bl[23:21] == 3'h7) ? 24'hFFFFFF
                                                                         : 24'h000000;
            end else begin
                col_dt[23:16] = (col_bl[23:21] > thr || col_bl[23:21] == 3'h7) ? 8'hFF : 8'h00;
                col_dt[15:8]  = (col_bl[15:13] > thr || col_bl[15:13] == 3'h7) ? 8'hFF : 8'h00;
                col_dt[7:0]   = (col_bl[7:5] > thr || col_bl[7:5] == 3'h7) ? 8'hFF : 8'h00;
            end
        end
    end

    // Output register
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pix_q <= '0;
        end else if (out_fire) begin
            pix_q.valid <= 1'b1;
            pix_q.sof   <= first_q;
            pix_q.eol   <= last_slot && last_word_q;
            pix_q.rgb   <= col_dt;
        end else if (pix_ready) begin
            pix_q.valid <= 1'b0;
        end
    end

    assign mem_req = mem_req_q;
    assign pix_out = pix_q;

endmodule : rpp_pipeline

//--- bench/rpp_pipeline_sva.sv
// Checker for the raster pixel pipeline ports
module rpp_pipeline_chk (
    input wire logic               clk,         // Pixel clock
    input wire logic               rst_b,       // Synchronous reset, low
    input wire logic               vram_sel,    // Video memory select
    input wire rpp_pkg::rpp_mreq_t mem_req,     // Memory read request
    input wire logic               mem_ack,     // Request taken
    input wire rpp_pkg::rpp_pix_t  pix_out,     // Pixel stream
    input wire logic               pix_ready,   // Display takes a pixel
    input wire logic [7:0]         frame_cnt_q  // Frame counter
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    property p_req_hold;
        mem_req.valid && !mem_ack |=> mem_req.valid && $stable(mem_req.addr);
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("request changed before ack");
    property p_req_drop;
        mem_req.valid && mem_ack |=> !mem_req.valid;
    endproperty
    a_req_drop: assert property (p_req_drop) else $error("request held after ack");
    property p_align;
        mem_req.valid |-> mem_req.addr[1:0] == rpp_pkg::RPP_WORD_ALIGN;
    endproperty
    a_align: assert property (p_align) else $error("request not word aligned");
    property p_vram;
        mem_req.valid |-> mem_req.vram == vram_sel;
    endproperty
    a_vram: assert property (p_vram) else $error("memory region select wrong");
    property p_pix_hold;
        pix_out.valid && !pix_ready |=> pix_out.valid && $stable(pix_out.rgb);
    endproperty
    a_pix_hold: assert property (p_pix_hold) else $error("pixel dropped while stalled");
    property p_frame_step;
        $changed(frame_cnt_q) |-> frame_cnt_q == $past(frame_cnt_q) + 8'h01;
    endproperty
    a_frame_step: assert property (p_frame_step) else $error("frame count skipped");
    property p_reset_out;
        $rose(rst_b) |-> !pix_out.valid && !mem_req.valid
            && frame_cnt_q == rpp_pkg::RPP_FRAME_RST;
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("outputs not clear after reset");
    property p_sof_valid;
        pix_out.sof |-> pix_out.valid;
    endproperty
    a_sof_valid: assert property (p_sof_valid) else $error("frame start without pixel");
endmodule : rpp_pipeline_chk

bind rpp_pipeline rpp_pipeline_chk u_chk (.clk(clk), .rst_b(rst_b), .vram_sel(vram_sel),
    .mem_req(mem_req), .mem_ack(mem_ack), .pix_out(pix_out), .pix_ready(pix_ready),
    .frame_cnt_q(frame_cnt_q));

//--- bench/rpp_mem_model.sv
// Frame buffer memory model: one read at a time, fast or slow
module rpp_mem_model (
    input  wire logic               clk,        // Pixel clock
    input  wire logic               rst_b,      // Reset, low
    input  wire rpp_pkg::rpp_mreq_t mem_req,    // Read request
    input  wire logic               slow,       // Add ack and data latency
    input  wire logic               hi_only,    // Words hold 0000 low, FFFF high
    output logic                    mem_ack,    // Request taken
    output logic                    mem_rvalid, // Data valid
    output logic [31:0]             mem_rdata   // Data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] addr_log [$];
    logic [31:0] a;

    // Byte n of a word holds its own low address byte plus n
    function automatic logic [31:0] word_at(input logic [31:0] ad, input logic h);
        logic [7:0] b;
        b = ad[7:0];
        return h ? 32'hFFFF0000 : {b + 8'h03, b + 8'h02, b + 8'h01, b};
    endfunction : word_at

    initial begin
        mem_ack = 1'b0;
        mem_rvalid = 1'b0;
        mem_rdata = 32'h5A5A5A5A;
        forever begin
            @(negedge clk);
            if (rst_b === 1'b1 && mem_req.valid === 1'b1) begin
                repeat (slow ? 2 : 0) @(negedge clk);
                mem_ack = 1'b1;
                a = mem_req.addr;
                addr_log.push_back(a);
                @(negedge clk);
                mem_ack = 1'b0;
                repeat (slow ? 3 : 0) @(negedge clk);
                mem_rvalid = 1'b1;
                mem_rdata = word_at(a, hi_only);
                @(negedge clk);
                mem_rvalid = 1'b0;
                // Stale data inverted so a late sample cannot pass
                mem_rdata = ~mem_rdata;
            end
        end
    end
endmodule : rpp_mem_model

//--- bench/raster_pixel_pipeline_test.sv
// Testbench of the raster pixel pipeline
module raster_pixel_pipeline_test;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {rpp_pkg::rpp_depth_t d; logic ls, vr, sl, st; int np;} rpp_row_t;
    logic clk, rst_b, enable, vram_sel, lut_sel, pix_ready, mem_ack, mem_rvalid, slow, hi_only;
    logic stall, blink_phase_q, dither_en, dither_mono;
    rpp_pkg::rpp_depth_t depth;
    rpp_pkg::rpp_blink_t blink_mode;
    rpp_pkg::rpp_lutw_t lut_wr;
    rpp_pkg::rpp_mreq_t mem_req;
    rpp_pkg::rpp_pix_t pix_out;
    rpp_pkg::rpp_pix_t got [$];
    logic [31:0] mem_rdata, exp_w;
    logic [7:0] rate, frame_cnt_q, idx, blink_match, blink_operand;
    logic [23:0] background, exp_c;
    int fails, checks_done, cyc, ppw, wi, j, nd;
    rpp_row_t rows [4] = '{'{rpp_pkg::RPP_BPP8, 0, 0, 0, 0, 16},
        '{rpp_pkg::RPP_BPP8, 1, 1, 1, 1, 16}, '{rpp_pkg::RPP_BPP4, 0, 0, 1, 0, 32},
        '{rpp_pkg::RPP_BPP4, 1, 1, 0, 1, 32}};

    rpp_pipeline uut (.clk(clk), .rst_b(rst_b), .enable(enable), .depth(depth),
        .screen_start(32'h00000103), .vram_sel(vram_sel), .line_words(12'h002),
        .line_pitch(12'h003), .frame_lines(11'h002), .blink_period_register(rate),
        .blink_mask(8'hFF), .blink_match(blink_match), .blink_operand(blink_operand),
        .blink_mode(blink_mode), .background(background), .lut_sel(lut_sel),
        .dither_en(dither_en), .dither_mono(dither_mono), .lut_wr(lut_wr), .mem_req(mem_req),
        .mem_ack(mem_ack), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
        .pix_out(pix_out), .pix_ready(pix_ready), .blink_phase_q(blink_phase_q),
        .frame_cnt_q(frame_cnt_q));
    rpp_mem_model mem (.clk(clk), .rst_b(rst_b), .mem_req(mem_req), .slow(slow),
        .hi_only(hi_only), .mem_ack(mem_ack), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Display stalls one cycle in three when asked
    always @(negedge clk) begin
        cyc <= cyc + 1;
        pix_ready <= !(stall && cyc % 3 == 0);
    end
    always @(posedge clk) if (pix_out.valid === 1'b1 && pix_ready === 1'b1) got.push_back(pix_out);

    function automatic logic [23:0] lut_c(input logic s, input logic [7:0] i);
        return s ? {~i, i, i} : {i, ~i, i ^ 8'h5A};
    endfunction : lut_c

    // Colour of a flagged table-0 pixel in the off phase, per blink mode
    function automatic logic [23:0] blk_c(input int md, input logic [7:0] i);
        logic [23:0] c;
        c = lut_c(1'b0, i);
        case (md)
            0:       return lut_c(1'b0, i & blink_operand);
            1:       return lut_c(1'b0, i | blink_operand);
            2:       return lut_c(1'b0, i ^ blink_operand);
            3:       return background;
            4:       return (c >> rpp_pkg::RPP_DIM_SHIFT) & 24'h7F7F7F;
            5:       return c | 24'h808080;
            default: return ~c;
        endcase
    endfunction : blk_c

    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : cmp

    task automatic wait_pix(input int n);
        int t;
        t = 0;
        while (got.size() < n && t < 4000) begin
            @(posedge clk);
            t++;
        end
        if (t == 4000) cmp(got.size(), n);
    endtask : wait_pix

    task automatic run_frame(input int n);
        @(negedge clk);
        got.delete();
        mem.addr_log.delete();
        enable = 1'b1;
        repeat (2) @(negedge clk);
        // Frame runs to its end once started
        enable = 1'b0;
        wait_pix(n);
        repeat (30) @(negedge clk);
    endtask : run_frame

    task automatic print_verdict;
        $display("checks_done=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : print_verdict

    initial begin
        #(8 * 80000);
        fails++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, 0, 1);
        print_verdict();
    end

    initial begin
        {rst_b, enable, vram_sel, lut_sel, slow, hi_only, stall, dither_en, dither_mono, cyc} = '0;
        {blink_match, blink_operand, background} = {8'h05, 8'h80, 24'h123456};
        {fails, checks_done} = '0;
        pix_ready = 1'b1;
        depth = rpp_pkg::RPP_BPP8;
        blink_mode = rpp_pkg::RPP_BLK_BACK;
        rate = 8'hFF;
        lut_wr = '0;
        repeat (3) @(negedge clk);
        rst_b = 1'b1;
        @(negedge clk);
        cmp({mem_req.valid, pix_out.valid, frame_cnt_q}, 32'h0);
        for (int s = 0; s < 2; s++) begin
            for (int i = 0; i < 256; i++) begin
                @(negedge clk);
                lut_wr = '{we: 1'b1, sel: s[0], idx: i[7:0], color: lut_c(s[0], i[7:0])};
            end
        end
        @(negedge clk);
        lut_wr = '0;
        foreach (rows[r]) begin
            depth = rows[r].d;
            {lut_sel, vram_sel, slow, stall} = {rows[r].ls, rows[r].vr, rows[r].sl, rows[r].st};
            ppw = depth == rpp_pkg::RPP_BPP4 ? 8 : 4;
            run_frame(rows[r].np);
            cmp(got.size(), rows[r].np);
            for (int k = 0; k < 4; k++)
                cmp(mem.addr_log[k], 32'h100 + 32'h4 * ((k / 2) * 3 + k % 2));
            foreach (got[k]) begin
                wi = k / ppw;
                j = k % ppw;
                exp_w = mem.word_at(32'h100 + 32'h4 * ((wi / 2) * 3 + wi % 2), 1'b0);
                idx = ppw == 4 ? exp_w[8*j+:8] : exp_w[8*(j/2)+:8] >> (j % 2 ? 0 : 4);
                if (ppw == 8) idx[7:4] = 4'h0;
                cmp(got[k].rgb, lut_c(lut_sel, idx));
                cmp({got[k].sof, got[k].eol}, {k == 0, k % (2 * ppw) == 2 * ppw - 1});
            end
        end
        hi_only = 1'b1;
        depth = rpp_pkg::RPP_BPP16;
        run_frame(8);
        cmp(got[0].rgb, 24'h0);
        cmp(got[1].rgb, 24'hF8FCF8);
        hi_only = 1'b0;
        depth = rpp_pkg::RPP_BPP8;
        {lut_sel, stall, rate} = '0;
        for (int m = 0; m < 7; m++) begin
            blink_mode = rpp_pkg::rpp_blink_t'(m);
            @(negedge clk);
            got.delete();
            enable = 1'b1;
            wait_pix(17);
            @(negedge clk);
            enable = 1'b0;
            wait_pix(32);
            cmp(got.size(), 32);
            nd = 0;
            foreach (got[k]) begin
                idx = k % 16 < 8 ? k % 16 : k % 16 + 4;
                exp_c = lut_c(1'b0, idx);
                if (idx == blink_match) begin
                    nd += got[k].rgb !== exp_c;
                    // Second frame of each pair runs in the off phase
                    if (k >= 16) exp_c = blk_c(m, idx);
                end
                cmp(got[k].rgb, exp_c);
            end
            // Rate zero flips the phase every frame: one of two frames blinks
            cmp(nd, 1);
            repeat (60) @(negedge clk);
        end
        // Colour dither: blue of shade 2 lights 2 of the 8 positions of a line
        {dither_en, lut_sel, blink_match} = {1'b1, 1'b0, 8'hFF};
        run_frame(16);
        nd = 0;
        foreach (got[k]) begin
            cmp(got[k].rgb[23:8], 32'h00FF);
            nd += got[k].rgb[7:0] == 8'hFF;
            if (k % 8 == 7) begin
                cmp(nd, 2);
                nd = 0;
            end
        end
        // Gray dither: shade 7 stays fully on
        {dither_mono, lut_sel} = 2'b11;
        run_frame(16);
        foreach (got[k]) cmp(got[k].rgb, 24'hFFFFFF);
        // Reset in mid frame clears request, pixel, blink phase and frame count; the LUTs keep their contents; the next frame starts clean
        {dither_en, dither_mono} = 2'b00;
        got.delete();
        enable = 1'b1;
        wait_pix(3);
        @(negedge clk);
        {rst_b, enable} = 2'b00;
        repeat (3) @(negedge clk);
        cmp({mem_req.valid, pix_out.valid, blink_phase_q, frame_cnt_q}, 32'h0);
        rst_b = 1'b1;
        run_frame(16);
        cmp(mem.addr_log[0], 32'h100);
        cmp({got[0].sof, got[0].rgb}, {1'b1, lut_c(lut_sel, 8'h00)});
        print_verdict();
    end
endmodule : raster_pixel_pipeline_test
